// file: core/vipc_ctrl.sv
// Vectored interrupt priority controller with APB register access.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module vipc_ctrl #(
   parameter int AW = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer1_req,
   input wire logic timer0_req,
   input wire logic adc_req,
   input wire logic comparator_req,
   input wire logic [7:0] port_a_pin,
   input wire logic [3:0] port_c_pin,
   input wire logic watchdog_req,
   input wire logic watchdog_irq_en,
   input wire logic posc_fail_trap,
   input wire logic wdosc_fail_trap,
   input wire logic illegal_instr_trap,
   input wire logic trap_instruction,
   input wire logic enable_irqs_instruction,
   input wire logic disable_irqs_instruction,
   input wire logic return_from_service_instruction,
   input wire logic irq_ack,
   output logic irq_to_core,
   output logic [15:0] irq_vector,
   output logic global_irq_enable_flag
);
   localparam int N = vipc_pkg::SRC_N;

   logic [N-1:0] req_q;
   logic [N-1:0] req_d;
   logic [N-1:0] en_hi_q;
   logic [N-1:0] en_lo_q;
   logic [vipc_pkg::NMI_N-1:0] nmi_q;
   logic [vipc_pkg::NMI_N-1:0] nmi_d;
   logic [7:0] edge_fall_q;
   logic ge_q;
   logic ge_d;
   logic fwd_q;
   logic fwd_d;
   logic [15:0] vec_q;
   logic [15:0] vec_d;
   logic sel_nmi_q;
   logic sel_nmi_d;
   logic [3:0] sel_idx_q;
   logic [3:0] sel_idx_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_data;
   logic rd_hit;
   logic [7:0] pa_pulse;
   logic [3:0] pc_pulse;
   logic [N-1:0] hw_set;
   logic [N-1:0] wr_mask;
   logic [N-1:0] wr_val;
   logic [N-1:0] ack_clr;
   logic [N-1:0] mask_cand;
   logic [7:0] img_req0;
   logic [7:0] img_req1;
   logic [7:0] img_req2;
   logic [7:0] img_h0;
   logic [7:0] img_h1;
   logic [7:0] img_h2;
   logic [7:0] img_l0;
   logic [7:0] img_l1;
   logic [7:0] img_l2;
   logic acc;
   logic wr_en;
   logic ack_ok;
   logic ge_set;
   logic ge_clr;

   // GPIO edge detection: port A selectable, port C on both edges.
   vipc_edge_detect #(.WIDTH(8), .BOTH_EDGES(1'b0)) u_port_a (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port_a_pin),
      .fall_sel(edge_fall_q),
      .edge_pulse(pa_pulse)
   );
   vipc_edge_detect #(.WIDTH(4), .BOTH_EDGES(1'b1)) u_port_c (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(port_c_pin),
      .fall_sel(4'h0),
      .edge_pulse(pc_pulse)
   );

   // Bus access strobes and address decode.
   assign acc = psel & penable & pready_q;
   assign wr_en = acc & pwrite;
   assign ack_ok = irq_ack & fwd_q;
   logic wr_req0, wr_req1, wr_req2, wr_h0, wr_h1, wr_h2;
   logic wr_l0, wr_l1, wr_l2, wr_ctrl, wr_edge;
   assign wr_req0 = wr_en && paddr == AW'(vipc_pkg::OFS_REQ0);
   assign wr_req1 = wr_en && paddr == AW'(vipc_pkg::OFS_REQ1);
   assign wr_req2 = wr_en && paddr == AW'(vipc_pkg::OFS_REQ2);
   assign wr_h0 = wr_en && paddr == AW'(vipc_pkg::OFS_ENH0);
   assign wr_l0 = wr_en && paddr == AW'(vipc_pkg::OFS_ENL0);
   assign wr_h1 = wr_en && paddr == AW'(vipc_pkg::OFS_ENH1);
   assign wr_l1 = wr_en && paddr == AW'(vipc_pkg::OFS_ENL1);
   assign wr_h2 = wr_en && paddr == AW'(vipc_pkg::OFS_ENH2);
   assign wr_l2 = wr_en && paddr == AW'(vipc_pkg::OFS_ENL2);
   assign wr_ctrl = wr_en && paddr == AW'(vipc_pkg::OFS_CTRL);
   assign wr_edge = wr_en && paddr == AW'(vipc_pkg::OFS_EDGE);

   // Hardware request pulses per source; comparator merges with pin six.
   assign hw_set[0] = timer1_req;
   assign hw_set[1] = timer0_req;
   assign hw_set[2] = adc_req;
   assign hw_set[vipc_pkg::SRC_PA+1] = pa_pulse[6] | comparator_req;
   assign hw_set[vipc_pkg::SRC_PA] = pa_pulse[7];
   assign hw_set[vipc_pkg::SRC_PA+7:vipc_pkg::SRC_PA+2] = {
      pa_pulse[0], pa_pulse[1], pa_pulse[2],
      pa_pulse[3], pa_pulse[4], pa_pulse[5]};
   assign hw_set[vipc_pkg::SRC_PC+3:vipc_pkg::SRC_PC] = {
      pc_pulse[0], pc_pulse[1], pc_pulse[2], pc_pulse[3]};

   // Register images: source index order maps onto register bits in reverse order.
   function automatic logic [7:0] img0(input logic [N-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      r[vipc_pkg::BIT_T1] = v[0];
      r[vipc_pkg::BIT_T0] = v[1];
      r[vipc_pkg::BIT_ADC] = v[2];
      return r;
   endfunction : img0
   function automatic logic [7:0] img1(input logic [N-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int p = 0; p < 8; p++)
         r[p] = v[vipc_pkg::SRC_PA+7-p];
      return r;
   endfunction : img1
   function automatic logic [7:0] img2(input logic [N-1:0] v);
      logic [7:0] r;
      r = 8'h00;
      for (int p = 0; p < 4; p++)
         r[p] = v[vipc_pkg::SRC_PC+3-p];
      return r;
   endfunction : img2
   // Scatter a written byte of one register group back onto sources.
   function automatic logic [N-1:0] spread(input logic s0, input logic s1,
      input logic s2, input logic [7:0] d);
      logic [N-1:0] r;
      r = '0;
      if (s0)
      begin
         r[0] = d[vipc_pkg::BIT_T1];
         r[1] = d[vipc_pkg::BIT_T0];
         r[2] = d[vipc_pkg::BIT_ADC];
      end
      for (int p = 0; p < 8; p++)
         if (s1)
            r[vipc_pkg::SRC_PA+7-p] = d[p];
      for (int p = 0; p < 4; p++)
         if (s2)
            r[vipc_pkg::SRC_PC+3-p] = d[p];
      return r;
   endfunction : spread

   assign img_req0 = img0(req_q);
   assign img_req1 = img1(req_q);
   assign img_req2 = img2(req_q);
   assign img_h0 = img0(en_hi_q);
   assign img_h1 = img1(en_hi_q);
   assign img_h2 = img2(en_hi_q);
   assign img_l0 = img0(en_lo_q);
   assign img_l1 = img1(en_lo_q);
   assign img_l2 = img2(en_lo_q);
   assign wr_mask = spread(wr_req0, wr_req1, wr_req2, 8'hFF);
   assign wr_val = spread(wr_req0, wr_req1, wr_req2, pwdata[7:0]);

   // Request bits: a hardware pulse wins over any same-cycle clear.
   always_comb
   begin
      ack_clr = '0;
      if (ack_ok && !sel_nmi_q)
         ack_clr[sel_idx_q] = 1'b1;
   end
   assign req_d = hw_set
      | (wr_mask & wr_val)
      | (req_q & ~(wr_mask & ~wr_val) & ~ack_clr);

   // Non-maskable events are sticky until their acknowledge.
   always_comb
   begin
      nmi_d = nmi_q;
      if (ack_ok && sel_nmi_q)
         nmi_d[sel_idx_q[2:0]] = 1'b0;
      nmi_d = nmi_d | {illegal_instr_trap, wdosc_fail_trap, posc_fail_trap,
         watchdog_req & watchdog_irq_en, 1'b0};
   end

   // Global enable: set events win over clear events in the same cycle.
   assign ge_set = enable_irqs_instruction | return_from_service_instruction
      | (wr_ctrl & pwdata[vipc_pkg::BIT_GE]);
   assign ge_clr = disable_irqs_instruction | ack_ok | trap_instruction
      | illegal_instr_trap | posc_fail_trap | wdosc_fail_trap
      | (wr_ctrl & ~pwdata[vipc_pkg::BIT_GE]);
   assign ge_d = ge_set | (ge_q & ~ge_clr);

   // Arbitration: non-maskable first, then highest level, then order.
   always_comb
   begin
      logic [1:0] best;
      logic [1:0] lvl;
      best = vipc_pkg::LVL_OFF;
      lvl = vipc_pkg::LVL_OFF;
      sel_nmi_d = 1'b0;
      sel_idx_d = 4'h0;
      vec_d = 16'h0000;
      mask_cand = req_q & (en_hi_q | en_lo_q) & {N{ge_q}};
      for (int i = 0; i < N; i++)
      begin
         lvl = {en_hi_q[i], en_lo_q[i]};
         if (mask_cand[i] && lvl > best)
         begin
            best = lvl;
            sel_idx_d = 4'(i);
            vec_d = vipc_pkg::SRC_VEC[i];
         end
      end
      for (int k = vipc_pkg::NMI_N - 1; k >= 0; k--)
      begin
         if (nmi_q[k])
         begin
            sel_nmi_d = 1'b1;
            sel_idx_d = 4'(k);
            vec_d = vipc_pkg::NMI_VEC[k];
         end
      end
      fwd_d = (sel_nmi_d | (|mask_cand)) & ~ack_ok;
   end

   // Read data selection.
   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = 32'h0000_0000;
      if (paddr == AW'(vipc_pkg::OFS_REQ0))
         rd_data[7:0] = img_req0;
      else if (paddr == AW'(vipc_pkg::OFS_REQ1))
         rd_data[7:0] = img_req1;
      else if (paddr == AW'(vipc_pkg::OFS_REQ2))
         rd_data[7:0] = img_req2;
      else if (paddr == AW'(vipc_pkg::OFS_ENH0))
         rd_data[7:0] = img_h0;
      else if (paddr == AW'(vipc_pkg::OFS_ENL0))
         rd_data[7:0] = img_l0;
      else if (paddr == AW'(vipc_pkg::OFS_ENH1))
         rd_data[7:0] = img_h1;
      else if (paddr == AW'(vipc_pkg::OFS_ENL1))
         rd_data[7:0] = img_l1;
      else if (paddr == AW'(vipc_pkg::OFS_ENH2))
         rd_data[7:0] = img_h2;
      else if (paddr == AW'(vipc_pkg::OFS_ENL2))
         rd_data[7:0] = img_l2;
      else if (paddr == AW'(vipc_pkg::OFS_CTRL))
         rd_data[vipc_pkg::BIT_GE] = ge_q;
      else if (paddr == AW'(vipc_pkg::OFS_EDGE))
         rd_data[7:0] = edge_fall_q;
      else if (paddr == AW'(vipc_pkg::OFS_STAT))
         rd_data = {vec_q, 7'h00, fwd_q, 3'h0, nmi_q};
      else
         rd_hit = 1'b0;
   end

   // Bus slave: answer comes one cycle after setup, with no wait.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else if (psel && !penable)
      begin
         pready_q <= 1'b1;
         pslverr_q <= ~rd_hit;
         prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
      end
      else if (acc)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_hi_q <= '0;
         en_lo_q <= '0;
         edge_fall_q <= vipc_pkg::EDGE_RST;
      end
      else
      begin
         en_hi_q <= (en_hi_q & ~spread(wr_h0, wr_h1, wr_h2, 8'hFF))
            | spread(wr_h0, wr_h1, wr_h2, pwdata[7:0]);
         en_lo_q <= (en_lo_q & ~spread(wr_l0, wr_l1, wr_l2, 8'hFF))
            | spread(wr_l0, wr_l1, wr_l2, pwdata[7:0]);
         if (wr_edge)
            edge_fall_q <= pwdata[7:0];
      end
   end

   // Pending state and outputs toward the core.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_q <= '0;
         nmi_q <= vipc_pkg::NMI_RST;
         ge_q <= 1'b0;
         fwd_q <= 1'b0;
         vec_q <= 16'h0000;
         sel_nmi_q <= 1'b0;
         sel_idx_q <= 4'h0;
      end
      else
      begin
         req_q <= req_d;
         nmi_q <= nmi_d;
         ge_q <= ge_d;
         fwd_q <= fwd_d;
         vec_q <= vec_d;
         sel_nmi_q <= sel_nmi_d;
         sel_idx_q <= sel_idx_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq_to_core = fwd_q;
   assign irq_vector = vec_q;
   assign global_irq_enable_flag = ge_q;

   // Checks on the arbitration and flag behaviour.
   ack_clears_req_a: assert property (@(posedge pclk) disable iff (!presetn)
      ack_ok && !sel_nmi_q && !hw_set[sel_idx_q] && !wr_req0 && !wr_req1
      && !wr_req2 |=> !req_q[$past(sel_idx_q)])
      else $error("Acknowledged request bit stayed set.");
   ack_drops_ge_a: assert property (@(posedge pclk) disable iff (!presetn)
      ack_ok && !ge_set |=> !ge_q)
      else $error("Global enable survived an acknowledge.");
   ei_sets_ge_a: assert property (@(posedge pclk) disable iff (!presetn)
      enable_irqs_instruction |=> ge_q)
      else $error("Enable instruction did not set global enable.");
   pulse_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer1_req |=> req_q[0])
      else $error("Timer pulse was not captured.");
   cmp_merge_a: assert property (@(posedge pclk) disable iff (!presetn)
      comparator_req |=> req_q[vipc_pkg::SRC_PA+1])
      else $error("Comparator pulse missed the shared bit.");
   no_fwd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      fwd_q && !sel_nmi_q |-> $past(ge_q))
      else $error("Maskable request forwarded while disabled.");
   nmi_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|nmi_q) && !ack_ok |=> fwd_q && sel_nmi_q)
      else $error("Non-maskable event not placed first.");
   reset_vec_a: assert property (@(posedge pclk) disable iff (!presetn)
      nmi_q[0] && !ack_ok |=> irq_vector == vipc_pkg::VEC_RESET)
      else $error("Reset vector not presented.");
   lvl3_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|(mask_cand & en_hi_q & en_lo_q)) && !(|nmi_q) && !ack_ok
      && !wr_en
      |=> fwd_q && en_hi_q[sel_idx_q] && en_lo_q[sel_idx_q])
      else $error("Level three request lost arbitration.");
   maskable_ack_c: cover property (@(posedge pclk) disable iff (!presetn)
      ack_ok && !sel_nmi_q);
   nmi_ack_c: cover property (@(posedge pclk) disable iff (!presetn)
      ack_ok && sel_nmi_q && sel_idx_q != 4'h0);
   sw_raise_c: cover property (@(posedge pclk) disable iff (!presetn)
      (|(wr_mask & wr_val)) ##1 fwd_q);
endmodule : vipc_ctrl

// file: core/vipc_pkg.sv
// Constants shared by the vectored interrupt priority controller.
package vipc_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFS_REQ0 = 8'h00;
   localparam logic [7:0] OFS_REQ1 = 8'h04;
   localparam logic [7:0] OFS_REQ2 = 8'h08;
   localparam logic [7:0] OFS_ENH0 = 8'h10;
   localparam logic [7:0] OFS_ENL0 = 8'h14;
   localparam logic [7:0] OFS_ENH1 = 8'h18;
   localparam logic [7:0] OFS_ENL1 = 8'h1C;
   localparam logic [7:0] OFS_ENH2 = 8'h20;
   localparam logic [7:0] OFS_ENL2 = 8'h24;
   localparam logic [7:0] OFS_CTRL = 8'h28;
   localparam logic [7:0] OFS_EDGE = 8'h2C;
   localparam logic [7:0] OFS_STAT = 8'h30;
   // Field positions.
   localparam int BIT_T1 = 6;
   localparam int BIT_T0 = 5;
   localparam int BIT_ADC = 0;
   localparam int BIT_GE = 7;
   localparam int STAT_FWD = 8;
   localparam int STAT_VEC = 16;
   // Reset values.
   localparam logic [7:0] EDGE_RST = 8'h00;
   localparam logic [4:0] NMI_RST = 5'h01;
   // Maskable sources: 0 second timer, 1 first timer, 2 converter,
   // 3..10 port A pins 7..0, 11..14 port C pins 3..0.
   localparam int SRC_N = 15;
   localparam int SRC_PA = 3;
   localparam int SRC_PC = 11;
   localparam int NMI_N = 5;
   // Enable codes.
   localparam logic [1:0] LVL_OFF = 2'h0;
   localparam logic [1:0] LVL_1 = 2'h1;
   localparam logic [1:0] LVL_3 = 2'h3;
   // Vectors of non-maskable events, index 0 (highest priority) last.
   localparam logic [15:0] VEC_RESET = 16'h0002;
   localparam logic [NMI_N-1:0][15:0] NMI_VEC = {
      16'h0006, 16'h003C, 16'h003A, 16'h0004, 16'h0002};
   // Vectors of maskable sources, index 0 last.
   localparam logic [SRC_N-1:0][15:0] SRC_VEC = {
      16'h0036, 16'h0034, 16'h0032, 16'h0030,
      16'h0026, 16'h0024, 16'h0022, 16'h0020,
      16'h001E, 16'h001C, 16'h001A, 16'h0018,
      16'h0016, 16'h000C, 16'h000A};
endpackage : vipc_pkg

// file: core/vipc_edge_detect.sv
// Pin synchroniser and edge detector that emits one-cycle request pulses.
`timescale 1ns/100ps
module vipc_edge_detect #(
   parameter int WIDTH = 8,
   parameter bit BOTH_EDGES = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] fall_sel,
   output logic [WIDTH-1:0] edge_pulse
);
   logic [WIDTH-1:0] sync1_q;
   logic [WIDTH-1:0] sync2_q;
   logic [WIDTH-1:0] prev_q;
   logic [WIDTH-1:0] pulse_q;
   logic [WIDTH-1:0] rise;
   logic [WIDTH-1:0] fall;
   logic [WIDTH-1:0] hit_d;

   // Edge terms look only at the second stage and its delayed copy.
   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;
   assign hit_d = BOTH_EDGES ? (rise | fall) :
      ((fall & fall_sel) | (rise & ~fall_sel));
   assign edge_pulse = pulse_q;

   // Two-stage synchroniser, edge history and registered pulse.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
         pulse_q <= '0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
         pulse_q <= hit_d;
      end
   end

   pulse_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
      (|pulse_q) |-> $past(sync2_q != prev_q))
      else $error("Edge pulse without a pin change.");
endmodule : vipc_edge_detect

// file: test/vipc_core_model.sv
// Behavioural processor core that acknowledges presented requests.
`timescale 1ns/100ps
module vipc_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ack_en,
   input wire logic [3:0] dly,
   input wire logic irq_to_core,
   input wire logic [15:0] irq_vector,
   output logic irq_ack,
   output logic [15:0] last_vec,
   output int n_ack
);
   logic [3:0] cnt_q;

   // Waits dly cycles on a presented request, then acknowledges it once.
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_ack <= 1'b0;
         cnt_q <= 4'h0;
         n_ack <= 0;
         last_vec <= 16'h0000;
      end
      else if (irq_ack)
      begin
         irq_ack <= 1'b0;
         last_vec <= irq_vector; // Even fetch address, MSB first
         n_ack <= n_ack + 1;
         cnt_q <= 4'h0;
      end
      else if (ack_en && irq_to_core)
      begin
         cnt_q <= cnt_q + 4'h1;
         irq_ack <= (cnt_q >= dly);
      end
      else
         cnt_q <= 4'h0;
   end
endmodule : vipc_core_model

// file: test/vectored_irq_priority_ctrl_bench.sv
// Self-checking bench for the vectored interrupt priority controller.
`timescale 1ns/100ps
module vectored_irq_priority_ctrl_bench;
   localparam logic [11:0] T1 = 12'h001, T0 = 12'h002, ADC = 12'h004;
   localparam logic [11:0] CMP = 12'h008, WD = 12'h010, PO = 12'h020;
   localparam logic [11:0] WO = 12'h040, IL = 12'h080, TR = 12'h100;
   localparam logic [11:0] ENI = 12'h200, DSI = 12'h400, RET = 12'h800;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq_ack, irq_to_core, ge, err;
   logic [11:0] ev = 12'h000;
   logic [7:0] pa = 8'h00;
   logic [3:0] pc = 4'h0;
   logic wd_en = 1'b0, ack_en = 1'b1;
   logic [3:0] dly = 4'h0;
   logic [15:0] irq_vector, last_vec;
   int n_ack, n_fail = 0, n_tests = 0, cyc = 0;

   // Clock toggles every half period of 10 ns.
   always #10 pclk = ~pclk;

   // Controller and the core model on its far side.
   vipc_ctrl #(.AW(8)) vipc_ctrl_i (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer1_req(ev[0]), .timer0_req(ev[1]),
      .adc_req(ev[2]), .comparator_req(ev[3]), .port_a_pin(pa),
      .port_c_pin(pc), .watchdog_req(ev[4]), .watchdog_irq_en(wd_en),
      .posc_fail_trap(ev[5]), .wdosc_fail_trap(ev[6]),
      .illegal_instr_trap(ev[7]), .trap_instruction(ev[8]),
      .enable_irqs_instruction(ev[9]), .disable_irqs_instruction(ev[10]),
      .return_from_service_instruction(ev[11]), .irq_ack(irq_ack),
      .irq_to_core(irq_to_core), .irq_vector(irq_vector),
      .global_irq_enable_flag(ge));
   vipc_core_model vipc_core_model_i (.pclk(pclk), .presetn(presetn),
      .ack_en(ack_en), .dly(dly), .irq_to_core(irq_to_core),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .last_vec(last_vec),
      .n_ack(n_ack));

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; answer taken at the rising edge that shows pready.
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, {24'h0, e});
   endtask : rdc

   task automatic pulse(input logic [11:0] m);
      @(posedge pclk);
      ev <= m;
      @(posedge pclk);
      ev <= 12'h000;
   endtask : pulse

   task automatic chk_ge(input logic e);
      @(negedge pclk);
      chk("global enable", {31'h0, ge}, {31'h0, e});
   endtask : chk_ge

   // Waits until n_ack moves off n; only the bench timeout ends a missing acknowledge.
   task automatic wait_ack(input int n);
      while (n_ack == n)
         @(posedge pclk);
   endtask : wait_ack

   // Re-enables through a return, then expects the next acknowledged vector.
   task automatic serve(input logic [15:0] e);
      int n;
      n = n_ack;
      pulse(RET);
      wait_ack(n);
      chk("vector", {16'h0, last_vec}, {16'h0, e});
   endtask : serve

   function automatic logic [15:0] exp_vec(input int i);
      if (i < 2) return 16'h000A + 16'(2 * i);
      if (i == 2) return 16'h0016;
      if (i < 11) return 16'h0018 + 16'(2 * (i - 3));
      return 16'h0030 + 16'(2 * (i - 11));
   endfunction : exp_vec

   task automatic t_reset();
      wait_ack(0);
      chk("reset vector", {16'h0, last_vec}, 32'h2);
      chk_ge(1'b0);
      for (int i = 0; i < 12; i++)
         if (i != 3)
            rdc("reset value", 8'(4 * i), 8'h00);
      rdc("unmapped", 8'h0C, 8'h00);
      chk("slave error", {31'h0, err}, 32'h1);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_order();
      wr(8'h14, 8'h61);
      wr(8'h1C, 8'hFF);
      wr(8'h24, 8'h0F);
      wr(8'h00, 8'h61);
      wr(8'h04, 8'hFF);
      wr(8'h08, 8'h0F);
      @(negedge pclk);
      chk("forwarded", {31'h0, irq_to_core}, 32'h0);
      rdc("request 1", 8'h04, 8'hFF);
      for (int i = 0; i < 15; i++)
         serve(exp_vec(i));
      for (int i = 0; i < 3; i++)
         rdc("cleared", 8'(4 * i), 8'h00);
      $display("t_order done");
   endtask : t_order

   task automatic t_levels();
      wr(8'h10, 8'h21);
      wr(8'h14, 8'h41);
      pulse(T1 | T0 | ADC);
      serve(16'h0016);
      serve(16'h000C);
      serve(16'h000A);
      $display("t_levels done");
   endtask : t_levels

   task automatic t_ge();
      ack_en <= 1'b0;
      pulse(ENI);
      chk_ge(1'b1);
      pulse(DSI);
      chk_ge(1'b0);
      pulse(ENI);
      pulse(TR);
      chk_ge(1'b0);
      wr(8'h28, 8'h80);
      chk_ge(1'b1);
      wr(8'h28, 8'h00);
      chk_ge(1'b0);
      $display("t_ge done");
   endtask : t_ge

   task automatic t_nmi();
      @(posedge pclk);
      dly <= 4'h3;
      wd_en <= 1'b1;
      wr(8'h10, 8'h40);
      wr(8'h14, 8'h40);
      wr(8'h28, 8'h80);
      pulse(T1 | WD | PO | WO | IL);
      chk_ge(1'b0);
      ack_en <= 1'b1;
      serve(16'h0004);
      serve(16'h003A);
      serve(16'h003C);
      serve(16'h0006);
      serve(16'h000A);
      wd_en <= 1'b0;
      dly <= 4'h0;
      $display("t_nmi done");
   endtask : t_nmi

   // Pin one watches falling edges; port C reacts to both edges.
   task automatic t_pins();
      wr(8'h2C, 8'h02);
      pa <= 8'h03;
      repeat (5) @(posedge pclk);
      rdc("port a", 8'h04, 8'h01);
      pa <= 8'h01;
      pulse(CMP);
      repeat (4) @(posedge pclk);
      rdc("port a", 8'h04, 8'h43);
      wr(8'h04, 8'h00);
      rdc("port a", 8'h04, 8'h00);
      pc <= 4'h1;
      repeat (5) @(posedge pclk);
      rdc("port c", 8'h08, 8'h01);
      wr(8'h08, 8'h00);
      pc <= 4'h0;
      repeat (5) @(posedge pclk);
      rdc("port c", 8'h08, 8'h01);
      wr(8'h08, 8'h00);
      $display("t_pins done");
   endtask : t_pins

   // A hardware pulse lands on the edge that takes a clearing write.
   task automatic t_race();
      fork
         wr(8'h00, 8'h00);
         begin
            repeat (2) @(posedge pclk);
            ev <= T0;
            @(posedge pclk);
            ev <= 12'h000;
         end
      join
      rdc("kept", 8'h00, 8'h20);
      wr(8'h00, 8'h00);
      $display("t_race done");
   endtask : t_race

   // Cuts a hung run short.
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         final_report();
      end
   end

   // Main sequence after six cycles of reset.
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_order();
      t_levels();
      t_ge();
      t_nmi();
      t_pins();
      t_race();
      final_report();
   end
endmodule : vectored_irq_priority_ctrl_bench
